// [logic/rpps_pin_select.sv]
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RESETN,
   // strap pins
   input wire logic I_PCI_SELECT_STRAP,
   input wire logic I_MAC_SELECT_STRAP,
   input wire logic I_HOST_WIDTH_STRAP,
   input wire logic I_EEPROM_AUTOINIT_STRAP,
   input wire logic I_ENDIAN_STRAP,
   input wire logic [3:0] I_MEMORY_INTERFACE_ADDRESS_PINS,
   input wire logic I_GENERAL_IO_PORT_0,
   // software gpio configuration for the upper general pins
   input wire logic [6:0] I_GPIO_ENABLE_BITS,
   input wire logic [6:0] I_GPIO_DIRECTION_BITS,
   // captured straps
   output logic [rpps_pkg::MEM_ADDR_STRAP_W-1:0] O_MEM_ADDR_STRAPS,
   output logic O_ENDIAN_STRAP,
   output logic O_CONFIG_INVALID,
   // peripheral enables
   output logic O_HOST_PORT_EN,
   output logic O_HOST_PORT_16BIT,
   output logic O_HOST_PORT_32BIT,
   output logic O_ETHERNET_MAC_SELECT_STRAP,
   output logic O_PCI_EN,
   output logic O_PCI_EEPROM_LOAD,
   output logic O_PCI_DEFAULTS,
   output logic O_ALWAYS_ON_EN,
   // pad controls
   output logic O_HOST_DATA_LOWER_HOST,
   output logic O_HOST_DATA_UPPER_HOST,
   output logic O_HOST_DATA_UPPER_MAC,
   output logic O_PCI_ONLY_PINS_OE,
   output logic O_UPPER_GPIO_PCI,
   output logic [6:0] O_UPPER_GPIO_SW_EN,
   output logic [6:0] O_UPPER_GPIO_OE,
   output logic [rpps_pkg::LOWER_GPIO_W-1:0] O_LOWER_GPIO_AVAIL
);
   // ************************************************************
   // reset release
   // ************************************************************
   logic [1:0] rst_sync_r;
   logic [1:0] rst_sync_nxt;
   logic rst_n;

   // a one walks in from the low end, so release lags the pin by two edges
   always_comb begin
      rst_sync_nxt = {rst_sync_r[0], 1'h1};
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= rst_sync_nxt;
      end
   end
   assign rst_n = rst_sync_r[1];

   // ************************************************************
   // strap capture
   // ************************************************************
   // straps track the pins while reset is held and freeze at release;
   // a reset flop may only take constants, so sampling is clocked
   rpps_pkg::rpps_straps_t straps_r, straps_nxt;
   rpps_pkg::rpps_sel_t sel_r, sel_nxt;
   logic [6:0] gpio_sw_r, gpio_sw_nxt;
   logic [6:0] gpio_oe_r, gpio_oe_nxt;
   logic in_reset_r;

   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         in_reset_r <= 1'h1;
      end else begin
         in_reset_r <= 1'h0;
      end
   end

   always_comb begin
      straps_nxt = straps_r;
      if (in_reset_r) begin
         straps_nxt.pci_select = I_PCI_SELECT_STRAP;
         straps_nxt.mac_select = I_MAC_SELECT_STRAP;
         straps_nxt.host_width = I_HOST_WIDTH_STRAP;
         straps_nxt.eeprom_autoinit = I_EEPROM_AUTOINIT_STRAP;
         straps_nxt.endian = I_ENDIAN_STRAP;
         straps_nxt.mem_addr = I_MEMORY_INTERFACE_ADDRESS_PINS;
         straps_nxt.low_gpio_high = I_GENERAL_IO_PORT_0;
      end
   end

   // sampling runs on the clock while the internal reset is low
   always_ff @(posedge I_CORE_CLK) begin
      straps_r <= straps_nxt;
   end

   // ************************************************************
   // selection decode
   // ************************************************************
   function automatic rpps_pkg::rpps_sel_t decode(input rpps_pkg::rpps_straps_t s);
      rpps_pkg::rpps_sel_t d;
      d = '0;
      d.config_invalid = s.low_gpio_high;
      // pci and mac both high has no defined use; pci wins so the pins never fight
      if (s.pci_select) begin
         d.pci_en = 1'h1;
         d.upper_gpio_pci = 1'h1;
         d.pci_only_pins_oe = 1'h1;
         d.pci_eeprom_load = s.eeprom_autoinit;
         d.pci_defaults = !s.eeprom_autoinit;
      end else begin
         d.upper_gpio_sw = 1'h1;
         d.ethernet_mac_select_strap = s.mac_select;
         if (!s.host_width) begin
            d.host_port_en = 1'h1;
            d.host_port_16bit = 1'h1;
            d.host_lower_drive = 1'h1;
            d.mac_upper_drive = s.mac_select;
         end else if (!s.mac_select) begin
            d.host_port_en = 1'h1;
            d.host_port_32bit = 1'h1;
            d.host_lower_drive = 1'h1;
            d.host_upper_drive = 1'h1;
         end else begin
            d.mac_upper_drive = 1'h1;
         end
      end
      return d;
   endfunction

   always_comb begin
      sel_nxt = decode(straps_r);
      gpio_sw_nxt = 7'h00;
      gpio_oe_nxt = 7'h00;
      // software gpio follows the enable bits; output enable needs both enable and direction set
      if (sel_nxt.upper_gpio_sw) begin
         gpio_sw_nxt = I_GPIO_ENABLE_BITS;
         gpio_oe_nxt = I_GPIO_ENABLE_BITS & I_GPIO_DIRECTION_BITS;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= '0;
         gpio_sw_r <= 7'h00;
         gpio_oe_r <= 7'h00;
      end else begin
         sel_r <= sel_nxt;
         gpio_sw_r <= gpio_sw_nxt;
         gpio_oe_r <= gpio_oe_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   logic [3:0] mem_addr_r;
   logic [3:0] mem_addr_nxt;
   logic endian_r;
   logic endian_nxt;
   logic always_on_r;
   logic always_on_nxt;

   // the copies reload from the frozen straps every edge, so they hold with them
   always_comb begin
      mem_addr_nxt = straps_r.mem_addr;
      endian_nxt = straps_r.endian;
      always_on_nxt = 1'h1;
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr_r <= rpps_pkg::RST_MEM_ADDR;
         endian_r <= rpps_pkg::RST_ENDIAN;
         always_on_r <= 1'h0;
      end else begin
         mem_addr_r <= mem_addr_nxt;
         endian_r <= endian_nxt;
         always_on_r <= always_on_nxt;
      end
   end

   assign O_MEM_ADDR_STRAPS = mem_addr_r;
   assign O_ENDIAN_STRAP = endian_r;
   assign O_CONFIG_INVALID = sel_r.config_invalid;

   // ************************************************************
   // peripheral enables
   // ************************************************************
   assign O_HOST_PORT_EN = sel_r.host_port_en;
   assign O_HOST_PORT_16BIT = sel_r.host_port_16bit;
   assign O_HOST_PORT_32BIT = sel_r.host_port_32bit;
   assign O_ETHERNET_MAC_SELECT_STRAP = sel_r.ethernet_mac_select_strap;
   assign O_PCI_EN = sel_r.pci_en;
   assign O_PCI_EEPROM_LOAD = sel_r.pci_eeprom_load;
   assign O_PCI_DEFAULTS = sel_r.pci_defaults;
   assign O_ALWAYS_ON_EN = always_on_r;

   // ************************************************************
   // pad controls
   // ************************************************************
   assign O_HOST_DATA_LOWER_HOST = sel_r.host_lower_drive;
   assign O_HOST_DATA_UPPER_HOST = sel_r.host_upper_drive;
   assign O_HOST_DATA_UPPER_MAC = sel_r.mac_upper_drive;
   assign O_PCI_ONLY_PINS_OE = sel_r.pci_only_pins_oe;
   assign O_UPPER_GPIO_PCI = sel_r.upper_gpio_pci;
   assign O_UPPER_GPIO_SW_EN = gpio_sw_r;
   assign O_UPPER_GPIO_OE = gpio_oe_r;
   assign O_LOWER_GPIO_AVAIL = {rpps_pkg::LOWER_GPIO_W{always_on_r}};
endmodule
`default_nettype wire

// [logic/rpps_pkg.sv]
`default_nettype none
package rpps_pkg;
   // ************************************************************
   // strap capture and decode constants
   // ************************************************************
   localparam int MEM_ADDR_STRAP_W = 4;
   localparam int LOWER_GPIO_W = 8;
   localparam int UPPER_GPIO_W = 7;
   localparam int HALF_DATA_W = 16;
   localparam int RST_SYNC_STAGES = 2;
   // reset values for the captured straps (the pins' default pulls)
   localparam logic RST_PCI_SEL = 1'h0;
   localparam logic RST_MAC_SEL = 1'h0;
   localparam logic RST_HOST_WIDTH = 1'h0;
   localparam logic RST_EEPROM_AI = 1'h0;
   localparam logic RST_ENDIAN = 1'h1;
   localparam logic [3:0] RST_MEM_ADDR = 4'h0;

   typedef struct packed {
      logic pci_select;
      logic mac_select;
      logic host_width;
      logic eeprom_autoinit;
      logic endian;
      logic [3:0] mem_addr;
      logic low_gpio_high;
   } rpps_straps_t;

   typedef struct packed {
      logic host_port_en;
      logic host_port_16bit;
      logic host_port_32bit;
      logic host_lower_drive;
      logic host_upper_drive;
      logic mac_upper_drive;
      logic ethernet_mac_select_strap;
      logic pci_en;
      logic pci_eeprom_load;
      logic pci_defaults;
      logic pci_only_pins_oe;
      logic upper_gpio_sw;
      logic upper_gpio_pci;
      logic config_invalid;
   } rpps_sel_t;
endpackage
`default_nettype wire

// [verif/rpps_board_pulls.sv]
`timescale 1ns/1ps
`default_nettype none
module rpps_board_pulls (
   // pull pattern on the board
   input wire rpps_pkg::rpps_straps_t i_pulls,
   // strap levels
   output logic o_pci, o_mac, o_width, o_autoinit, o_endian, o_gp0,
   output logic [3:0] o_addr
);
   assign o_pci = i_pulls.pci_select;
   assign o_mac = i_pulls.mac_select;
   assign {o_width, o_autoinit, o_endian, o_addr} = {i_pulls.host_width,
      i_pulls.eeprom_autoinit, i_pulls.endian, i_pulls.mem_addr};
   // pulled low; lifted only when the bench asks for a bad board
   assign o_gp0 = i_pulls.low_gpio_high;
endmodule
`default_nettype wire

// [verif/rpps_pin_select_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select_assertions (
   // clock, reset and watched ports
   input wire logic I_CORE_CLK, I_RESETN, O_PCI_EN, O_HOST_PORT_EN, O_ETHERNET_MAC_SELECT_STRAP,
   input wire logic O_PCI_ONLY_PINS_OE, O_UPPER_GPIO_PCI, O_PCI_EEPROM_LOAD, O_PCI_DEFAULTS,
   input wire logic O_HOST_PORT_16BIT, O_HOST_PORT_32BIT, O_HOST_DATA_LOWER_HOST,
   input wire logic O_HOST_DATA_UPPER_HOST, O_HOST_DATA_UPPER_MAC,
   input wire logic [6:0] I_GPIO_ENABLE_BITS,
   input wire logic [6:0] O_UPPER_GPIO_SW_EN
);
   // ****
   // settle counter
   // ****
   // the decode needs a few edges after release, so nothing is judged before then
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic rdy;
   always_comb cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
   always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
      if (!I_RESETN) cnt_r <= 3'h0;
      else cnt_r <= cnt_nxt;
   assign rdy = (cnt_r == 3'h7);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_pci; rdy && O_PCI_EN; endsequence
   sequence s_host; rdy && !O_PCI_EN; endsequence
   property p_pci_owns;
      s_pci |-> !O_HOST_PORT_EN && !O_ETHERNET_MAC_SELECT_STRAP && O_UPPER_GPIO_SW_EN == 7'h00;
   endproperty
   a_pci_owns: assert property (p_pci_owns) else $error("pci mode leaves host on");
   property p_pins; rdy |-> O_PCI_ONLY_PINS_OE == O_PCI_EN && O_UPPER_GPIO_PCI == O_PCI_EN;
   endproperty
   a_pins: assert property (p_pins) else $error("pci only pins wrong");
   property p_eeprom; s_pci |-> O_PCI_EEPROM_LOAD != O_PCI_DEFAULTS; endproperty
   a_eeprom: assert property (p_eeprom) else $error("pci init source wrong");
   property p_host_en; (s_host and !O_ETHERNET_MAC_SELECT_STRAP) |-> O_HOST_PORT_EN; endproperty
   a_host_en: assert property (p_host_en) else $error("host port off");
   property p_h16; rdy && O_HOST_PORT_16BIT |-> O_HOST_DATA_LOWER_HOST &&
      !O_HOST_DATA_UPPER_HOST && O_HOST_DATA_UPPER_MAC == O_ETHERNET_MAC_SELECT_STRAP; endproperty
   a_h16: assert property (p_h16) else $error("narrow host pins wrong");
   property p_h32; rdy && O_HOST_PORT_32BIT |-> O_HOST_DATA_LOWER_HOST &&
      O_HOST_DATA_UPPER_HOST && !O_ETHERNET_MAC_SELECT_STRAP; endproperty
   a_h32: assert property (p_h32) else $error("wide host pins wrong");
   property p_gpio; s_host |=> O_UPPER_GPIO_SW_EN == $past(I_GPIO_ENABLE_BITS); endproperty
   a_gpio: assert property (p_gpio) else $error("gpio enable not followed");
   property p_hold;
      rdy |=> $stable(O_PCI_EN) && $stable(O_HOST_PORT_EN) && $stable(O_ETHERNET_MAC_SELECT_STRAP);
   endproperty
   a_hold: assert property (p_hold) else $error("selection moved");
endmodule
`default_nettype wire

// [verif/rpps_pin_select_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select_tb_top;
   typedef struct packed {logic [3:0] sel; logic [3:0] addr; logic [11:0] exp;} rpps_row_t;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   rpps_pkg::rpps_straps_t pulls = '0;
   logic [6:0] gen = 7'h55;
   logic [6:0] gdir = 7'h33;
   wire logic pci, mac, wid, ai, endn, gp0, end_q, inval, aon;
   wire logic h_en, h16, h32, m_en, p_en, ee, dflt, lo_h, up_h, up_m, p_oe, up_p;
   wire logic [3:0] addr, mem_q;
   wire logic [7:0] low_av;
   wire logic [6:0] sw_en, oe;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   // sel is {pci, autoinit, width, mac}; last row stays in narrow host mode
   rpps_row_t rows [6] = '{'{4'he, 4'h3, 12'h0c3}, '{4'hb, 4'h6, 12'h0a3},
      '{4'h3, 4'hc, 12'h104}, '{4'h2, 4'h5, 12'ha18}, '{4'h1, 4'ha, 12'hd14},
      '{4'h0, 4'h9, 12'hc10}};
   rpps_board_pulls pb (.i_pulls(pulls), .o_pci(pci), .o_mac(mac), .o_width(wid),
      .o_autoinit(ai), .o_endian(endn), .o_gp0(gp0), .o_addr(addr));
   rpps_pin_select dut (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_PCI_SELECT_STRAP(pci),
      .I_MAC_SELECT_STRAP(mac), .I_HOST_WIDTH_STRAP(wid), .I_EEPROM_AUTOINIT_STRAP(ai),
      .I_ENDIAN_STRAP(endn), .I_MEMORY_INTERFACE_ADDRESS_PINS(addr), .I_GENERAL_IO_PORT_0(gp0),
      .I_GPIO_ENABLE_BITS(gen), .I_GPIO_DIRECTION_BITS(gdir), .O_MEM_ADDR_STRAPS(mem_q),
      .O_ENDIAN_STRAP(end_q), .O_CONFIG_INVALID(inval), .O_HOST_PORT_EN(h_en),
      .O_HOST_PORT_16BIT(h16), .O_HOST_PORT_32BIT(h32), .O_ETHERNET_MAC_SELECT_STRAP(m_en),
      .O_PCI_EN(p_en), .O_PCI_EEPROM_LOAD(ee), .O_PCI_DEFAULTS(dflt), .O_ALWAYS_ON_EN(aon),
      .O_HOST_DATA_LOWER_HOST(lo_h), .O_HOST_DATA_UPPER_HOST(up_h),
      .O_HOST_DATA_UPPER_MAC(up_m), .O_PCI_ONLY_PINS_OE(p_oe), .O_UPPER_GPIO_PCI(up_p),
      .O_UPPER_GPIO_SW_EN(sw_en), .O_UPPER_GPIO_OE(oe), .O_LOWER_GPIO_AVAIL(low_av));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         final_report();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task boot(input int n);
      rstn = 1'h0;
      repeat (n) @(posedge clk);
      #1 rstn = 1'h1;
      repeat (8) @(posedge clk);
      #1;
   endtask
   initial begin
      #1;
      foreach (rows[i]) begin
         {pulls.pci_select, pulls.eeprom_autoinit, pulls.host_width, pulls.mac_select} = rows[i].sel;
         {pulls.mem_addr, pulls.endian} = {rows[i].addr, rows[i].addr[0]};
         boot(i == 0 ? 16 : 4);
         chk({h_en, h16, h32, m_en, p_en, ee, dflt, lo_h, up_h, up_m, p_oe, up_p}, rows[i].exp);
         chk({end_q, mem_q}, {rows[i].addr[0], rows[i].addr});
         chk({sw_en, oe}, rows[i].sel[3] ? 14'h0 : {gen, gen & gdir});
         chk({inval, aon, low_av}, 10'h1ff);
         $display("row %0d done", i);
      end
      // straps flipped after release, bad low pin included, must change nothing
      pulls = '1;
      repeat (4) @(posedge clk);
      #1 chk({inval, p_en, h_en, m_en, mem_q}, 8'h29);
      {gen, gdir} = {7'h0f, 7'h7f};
      repeat (2) @(posedge clk);
      #1 chk({sw_en, oe}, {7'h0f, 7'h0f});
      $display("hold test done");
      pulls = '0;
      pulls.low_gpio_high = 1'h1;
      boot(4);
      chk(inval, 1'h1);
      $display("invalid strap test done");
      final_report();
   end
endmodule
bind rpps_pin_select rpps_pin_select_assertions u_chk (.I_CORE_CLK(I_CORE_CLK),
   .I_RESETN(I_RESETN), .O_PCI_EN(O_PCI_EN), .O_HOST_PORT_EN(O_HOST_PORT_EN),
   .O_ETHERNET_MAC_SELECT_STRAP(O_ETHERNET_MAC_SELECT_STRAP), .O_PCI_ONLY_PINS_OE(O_PCI_ONLY_PINS_OE),
   .O_UPPER_GPIO_PCI(O_UPPER_GPIO_PCI), .O_PCI_EEPROM_LOAD(O_PCI_EEPROM_LOAD),
   .O_PCI_DEFAULTS(O_PCI_DEFAULTS), .O_HOST_PORT_16BIT(O_HOST_PORT_16BIT),
   .O_HOST_PORT_32BIT(O_HOST_PORT_32BIT), .O_HOST_DATA_LOWER_HOST(O_HOST_DATA_LOWER_HOST),
   .O_HOST_DATA_UPPER_HOST(O_HOST_DATA_UPPER_HOST), .O_HOST_DATA_UPPER_MAC(O_HOST_DATA_UPPER_MAC),
   .I_GPIO_ENABLE_BITS(I_GPIO_ENABLE_BITS), .O_UPPER_GPIO_SW_EN(O_UPPER_GPIO_SW_EN));
`default_nettype wire
